/* core/serial_pkg.sv */
package serial_pkg;
	localparam int ADDR_W = 12;
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_STATUS = 10'h050;
	localparam logic [9:0] IDX_DATA = 10'h051;
	localparam logic [9:0] IDX_BAUD = 10'h052;
	localparam logic [9:0] IDX_RX_EXT = 10'h056;
	localparam logic [9:0] IDX_TX_EXT = 10'h057;
	// baud_divisor_select fields
	localparam int RX_DIV_LSB = 0;
	localparam int TX_DIV_LSB = 3;
	localparam int PRE_SEL_LSB = 6;
	// status fields
	localparam int ST_TX_SPACE = 7;
	localparam int ST_TX_IDLE = 6;
	localparam int ST_RX_FULL = 5;
	localparam int ST_OVERRUN = 3;
	// reset values
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [7:0] EXT_RST = 8'h00;
	localparam logic [7:0] HOLD_RST = 8'h00;
	// shared prescaler factors per shared_prescaler_sel code
	localparam logic [7:0] PRE_F0 = 8'h01;
	localparam logic [7:0] PRE_F1 = 8'h03;
	localparam logic [7:0] PRE_F2 = 8'h04;
	localparam logic [7:0] PRE_F3 = 8'h0d;
	// oversampling and framing counts
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] SUB_MID = 4'h7;
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam int FIFO_DEPTH = 4;
	localparam int DATA_W = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage : serial_pkg

/* core/serial_rate_data_unit.sv */
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns

module small_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk, // bus clock
	input wire logic nrst, // async reset, low
	input wire logic [WIDTH-1:0] in_data, // push data
	input wire logic in_valid, // push request
	output logic in_ready, // room for a word
	output logic [WIDTH-1:0] out_data, // head word
	output logic out_valid, // head word present
	input wire logic out_ready // pop request
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem[rd_reg];

	always_ff @(posedge clk)
		if (push)
			mem[wr_reg] <= in_data;

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wr_reg <= push ? wr_reg + 1'b1 : wr_reg;
			rd_reg <= pop ? rd_reg + 1'b1 : rd_reg;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
endmodule : small_fifo

module serial_rate_data_unit (
	input wire logic clk, // bus clock
	input wire logic nrst, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire serial_pkg::apb_req_t req, // apb address, direction, data
	output serial_pkg::apb_rsp_t rsp, // apb answer
	input wire logic rxd, // serial line in
	output logic txd // serial line out
);
	import serial_pkg::*;

	function automatic logic [7:0] step(input logic [7:0] c,
		input logic [7:0] lim);
		step = (c >= lim) ? 8'h00 : c + 8'h01;
	endfunction : step

	function automatic logic [7:0] pow2_lim(input logic [2:0] sel);
		pow2_lim = (8'h01 << sel) - 8'h01;
	endfunction : pow2_lim

	function automatic logic [7:0] ext_lim(input logic [7:0] ext);
		ext_lim = (ext == 8'h00) ? 8'h00 : ext - 8'h01;
	endfunction : ext_lim

	logic [7:0] baud_reg;
	logic [7:0] rx_ext_reg;
	logic [7:0] tx_ext_reg;
	logic [7:0] rx_holding_reg;
	logic rx_full_reg;
	logic overrun_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [7:0] pre_cnt_reg;
	logic [7:0] tx_div_reg;
	logic [7:0] rx_div_reg;
	logic [7:0] tx_ecnt_reg;
	logic [7:0] rx_ecnt_reg;
	logic [3:0] tx_sub_reg;
	logic [3:0] tx_cnt_reg;
	logic [8:0] tx_shift_reg;
	logic txd_reg;
	logic [3:0] rx_sub_reg;
	logic [3:0] rx_cnt_reg;
	logic [7:0] rx_shift_reg;
	logic rx_meta_reg;
	logic rx_sync_reg;

	// apb decode
	wire [9:0] idx = req.paddr[ADDR_W-1:2];
	wire hit_status = idx == IDX_STATUS;
	wire hit_data = idx == IDX_DATA;
	wire hit_baud = idx == IDX_BAUD;
	wire hit_rx_ext = idx == IDX_RX_EXT;
	wire hit_tx_ext = idx == IDX_TX_EXT;
	wire mapped = hit_status | hit_data | hit_baud | hit_rx_ext | hit_tx_ext;
	wire fifo_in_ready;
	// a data write waits while the transmit queue is full
	wire stall = req.pwrite & hit_data & ~fifo_in_ready;
	wire access = psel & penable;
	wire answer = access & ~pready_reg & ~stall;
	wire done = access & pready_reg;
	wire wr_ok = done & req.pwrite & ~pslverr_reg;
	// a data read frees the holding register at the edge that captures it
	wire rd_data = answer & ~req.pwrite & hit_data;

	// transmit queue
	wire [7:0] tx_head;
	wire tx_head_valid;
	wire tx_idle = tx_cnt_reg == 4'h0;
	wire tx_load = tx_idle & tx_head_valid;
	small_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_queue (
		.clk(clk),
		.nrst(nrst),
		.in_data(req.pwdata[7:0]),
		.in_valid(wr_ok & hit_data),
		.in_ready(fifo_in_ready),
		.out_data(tx_head),
		.out_valid(tx_head_valid),
		.out_ready(tx_load)
	);

	wire [7:0] status = {fifo_in_ready, tx_idle & ~tx_head_valid,
		rx_full_reg, 1'b0, overrun_reg, 3'b000};
	wire [7:0] rd_mux = hit_data ? rx_holding_reg :
		hit_baud ? baud_reg :
		hit_rx_ext ? rx_ext_reg :
		hit_tx_ext ? tx_ext_reg :
		hit_status ? status : 8'h00;

	// rate generation
	wire [1:0] pre_sel = baud_reg[PRE_SEL_LSB +: 2];
	wire [7:0] pre_f = (pre_sel == 2'd0) ? PRE_F0 :
		(pre_sel == 2'd1) ? PRE_F1 :
		(pre_sel == 2'd2) ? PRE_F2 : PRE_F3;
	wire [7:0] pre_lim = pre_f - 8'h01;
	wire pre_tick = pre_cnt_reg >= pre_lim;
	wire [7:0] tx_div_lim = pow2_lim(baud_reg[TX_DIV_LSB +: 3]);
	wire [7:0] rx_div_lim = pow2_lim(baud_reg[RX_DIV_LSB +: 3]);
	wire tx_div_tick = pre_tick & (tx_div_reg >= tx_div_lim);
	wire rx_div_tick = pre_tick & (rx_div_reg >= rx_div_lim);
	wire tx_tick = tx_div_tick & (tx_ecnt_reg >= ext_lim(tx_ext_reg));
	wire rx_tick = rx_div_tick & (rx_ecnt_reg >= ext_lim(rx_ext_reg));
	wire tx_bit_end = tx_tick & (tx_sub_reg == SUB_LAST);
	wire rx_mid = rx_tick & (rx_sub_reg == SUB_MID) & (rx_cnt_reg != 4'h0);
	wire rx_start = rx_tick & (rx_cnt_reg == 4'h0) & ~rx_sync_reg;
	wire rx_done = rx_mid & (rx_cnt_reg == 4'h1);

	// apb slave
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end
		else
		begin
			pready_reg <= answer;
			pslverr_reg <= answer & ~mapped;
			prdata_reg <= answer ? {24'h000000, rd_mux} : prdata_reg;
		end

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			baud_reg <= BAUD_RST;
			rx_ext_reg <= EXT_RST;
			tx_ext_reg <= EXT_RST;
		end
		else
		begin
			// rate writes only touch rate settings
			baud_reg <= (wr_ok & hit_baud) ? req.pwdata[7:0] : baud_reg;
			rx_ext_reg <= (wr_ok & hit_rx_ext) ? req.pwdata[7:0] : rx_ext_reg;
			tx_ext_reg <= (wr_ok & hit_tx_ext) ? req.pwdata[7:0] : tx_ext_reg;
		end

	// shared prescaler and separate divider chains
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			pre_cnt_reg <= 8'h00;
			tx_div_reg <= 8'h00;
			rx_div_reg <= 8'h00;
			tx_ecnt_reg <= 8'h00;
			rx_ecnt_reg <= 8'h00;
		end
		else
		begin
			pre_cnt_reg <= step(pre_cnt_reg, pre_lim);
			tx_div_reg <= pre_tick ? step(tx_div_reg, tx_div_lim) : tx_div_reg;
			rx_div_reg <= pre_tick ? step(rx_div_reg, rx_div_lim) : rx_div_reg;
			tx_ecnt_reg <= tx_div_tick ?
				step(tx_ecnt_reg, ext_lim(tx_ext_reg)) : tx_ecnt_reg;
			rx_ecnt_reg <= rx_div_tick ?
				step(rx_ecnt_reg, ext_lim(rx_ext_reg)) : rx_ecnt_reg;
		end

	// transmit shifter: start, 8 data lsb first, stop
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			tx_sub_reg <= 4'h0;
			tx_cnt_reg <= 4'h0;
			tx_shift_reg <= 9'h1ff;
			txd_reg <= 1'b1;
		end
		else if (tx_load)
		begin
			tx_sub_reg <= 4'h0;
			tx_cnt_reg <= FRAME_BITS;
			tx_shift_reg <= {1'b1, tx_head};
			txd_reg <= 1'b0;
		end
		else
		begin
			tx_sub_reg <= tx_tick ? tx_sub_reg + 4'h1 : tx_sub_reg;
			if (tx_bit_end & ~tx_idle)
			begin
				tx_cnt_reg <= tx_cnt_reg - 4'h1;
				tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
				txd_reg <= tx_shift_reg[0];
			end
		end

	// line input synchroniser
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end
		else
		begin
			rx_meta_reg <= rxd;
			rx_sync_reg <= rx_meta_reg;
		end

	// receive shifter: sample at mid bit
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			rx_sub_reg <= 4'h0;
			rx_cnt_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
		end
		else if (rx_start)
		begin
			rx_sub_reg <= 4'h0;
			rx_cnt_reg <= FRAME_BITS;
		end
		else
		begin
			rx_sub_reg <= rx_tick ? rx_sub_reg + 4'h1 : rx_sub_reg;
			if (rx_mid)
			begin
				// a high start sample was a glitch
				if (rx_cnt_reg == FRAME_BITS && rx_sync_reg)
					rx_cnt_reg <= 4'h0;
				else
					rx_cnt_reg <= rx_cnt_reg - 4'h1;
				if (rx_cnt_reg != FRAME_BITS && rx_cnt_reg != 4'h1)
					rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
			end
		end

	// receive holding and flags; a new byte beats a clearing read
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			rx_holding_reg <= HOLD_RST;
			rx_full_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end
		else
		begin
			rx_holding_reg <= (rx_done & (~rx_full_reg | rd_data)) ?
				rx_shift_reg : rx_holding_reg;
			rx_full_reg <= rx_done | (rx_full_reg & ~rd_data);
			overrun_reg <= (rx_done & rx_full_reg & ~rd_data) |
				(overrun_reg & ~rd_data);
		end

	assign rsp.prdata = prdata_reg;
	assign rsp.pready = pready_reg;
	assign rsp.pslverr = pslverr_reg;
	assign txd = txd_reg;
endmodule : serial_rate_data_unit

/* dv/rate_data_props.sv */
`timescale 1ns/1ns
module rate_data_props (
	input wire logic clk, // clock
	input wire logic nrst, // reset, low
	input wire logic psel, // select
	input wire logic penable, // access
	input wire serial_pkg::apb_req_t req, // request
	input wire serial_pkg::apb_rsp_t rsp, // answer
	input wire logic rxd, // line in
	input wire logic txd // line out
);
	import serial_pkg::*;
	logic [9:0] idx;
	logic mapped;
	logic [7:0] baud_reg;
	assign idx = req.paddr[11:2];
	assign mapped = idx == IDX_STATUS || idx == IDX_DATA || idx == IDX_BAUD
		|| idx == IDX_RX_EXT || idx == IDX_TX_EXT;
	// shadow of the last completed baud register write
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			baud_reg <= BAUD_RST;
		else if (rsp.pready && req.pwrite && idx == IDX_BAUD)
			baud_reg <= req.pwdata[7:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_pulse;
		rsp.pready ##1 !rsp.pready;
	endsequence
	sequence s_start;
		!txd [*8];
	endsequence
	property p_pulse;
		rsp.pready |-> s_pulse;
	endproperty
	property p_cause;
		rsp.pready |-> psel && penable && $past(psel && penable);
	endproperty
	property p_map;
		rsp.pready |-> rsp.pslverr == !mapped;
	endproperty
	property p_err_only;
		rsp.pslverr |-> rsp.pready;
	endproperty
	property p_err_zero;
		rsp.pready && rsp.pslverr |-> rsp.prdata == 32'h0;
	endproperty
	property p_upper;
		rsp.pready |-> rsp.prdata[31:8] == 24'h0;
	endproperty
	property p_baud_rd;
		rsp.pready && !req.pwrite && idx == IDX_BAUD
			|-> rsp.prdata[7:0] == baud_reg;
	endproperty
	property p_start;
		$fell(txd) |-> s_start;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("ready longer than one cycle");
	a_cause: assert property (p_cause)
		else $error("ready without access phase");
	a_map: assert property (p_map)
		else $error("error flag wrong for address");
	a_err_only: assert property (p_err_only)
		else $error("error flag without ready");
	a_err_zero: assert property (p_err_zero)
		else $error("refused read data not zero");
	a_upper: assert property (p_upper)
		else $error("read data upper bits set");
	a_baud_rd: assert property (p_baud_rd)
		else $error("divisor readback wrong");
	a_start: assert property (p_start)
		else $error("line low bit too short");
endmodule : rate_data_props
bind serial_rate_data_unit rate_data_props u_props (.clk(clk), .nrst(nrst),
	.psel(psel), .penable(penable), .req(req), .rsp(rsp), .rxd(rxd),
	.txd(txd));

/* dv/remote_serial.sv */
`timescale 1ns/1ns
module remote_serial (
	input wire logic clk, // clock
	input wire logic txd, // device out
	output logic rxd // device in
);
	int tx_bt = 16;
	int rx_bt = 16;
	logic [7:0] got[$];
	initial rxd = 1'b1;
	always
	begin : grab
		logic [7:0] b;
		@(negedge txd);
		repeat (tx_bt + tx_bt / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			b[i] = txd;
			repeat (tx_bt) @(posedge clk);
		end
		got.push_back(b);
	end
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxd <= f[i];
			repeat (rx_bt) @(posedge clk);
		end
	endtask : send
endmodule : remote_serial

/* dv/serial_rate_data_unit_tb.sv */
`timescale 1ns/1ns
module serial_rate_data_unit_tb;
	import serial_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic rxd;
	logic txd;
	int error_cnt = 0;
	int check_count = 0;
	int n;
	int bt;
	logic [7:0] seed = 8'h57;
	logic [7:0] b;
	logic [7:0] exp_q[$];
	logic [31:0] rd;
	logic err;
	logic ok;
	logic [9:0] regs[3] = '{IDX_BAUD, IDX_RX_EXT, IDX_TX_EXT};
	logic [7:0] pf[4] = '{PRE_F0, PRE_F1, PRE_F2, PRE_F3};
	serial_rate_data_unit uut (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .req(req), .rsp(rsp), .rxd(rxd), .txd(txd));
	remote_serial peer (.clk(clk), .txd(txd), .rxd(rxd));
	always #4 clk = ~clk;
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run;
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// expected bit time in clocks for one direction
	function automatic int bit_time(input logic [7:0] pre, input int div,
		input int ext);
		return 16 * pre * (1 << div) * (ext == 0 ? 1 : ext);
	endfunction : bit_time
	task automatic bound(input string what, input int n, input int lim);
		if (n >= lim)
		begin
			check(what, 32'd1, 32'd0);
			complete_run();
		end
	endtask : bound
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [7:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		req <= '{paddr: {idx, 2'b00}, pwrite: w, pwdata: {24'h0, d}};
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (rsp.pready !== 1'b1 && k < 20000);
		if (rsp.pready !== 1'b1)
		begin
			check("apb wait", 32'd1, 32'd0);
			complete_run();
		end
		else
		begin
			// answer taken at the edge where ready is sampled high
			rd = rsp.prdata;
			err = rsp.pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask : apb
	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b0, regs[i], 8'h00);
			check("reset", rd, 32'h0);
		end
		apb(1'b0, 10'h053, 8'h00);
		check("slverr", err, 32'd1);
		check("slverr data", rd, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			apb(1'b1, regs[i % 3], seed);
			apb(1'b0, regs[i % 3], 8'h00);
			check("rw", rd, {24'h0, seed});
		end
		for (int i = 0; i < 3; i++)
			apb(1'b1, regs[i], 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			exp_q.push_back(seed);
			apb(1'b1, IDX_DATA, seed);
		end
		for (n = 0; n < 5000 && peer.got.size() < 6; n++)
			@(posedge clk);
		bound("tx wait", n, 5000);
		check("tx count", peer.got.size(), 32'd6);
		foreach (exp_q[i])
			check("tx byte", peer.got[i], exp_q[i]);
		seed = lfsr(seed);
		b = seed;
		peer.send(b);
		seed = lfsr(seed);
		peer.send(seed);
		apb(1'b0, IDX_STATUS, 8'h00);
		check("overrun", rd[ST_OVERRUN], 32'd1);
		apb(1'b0, IDX_DATA, 8'h00);
		check("rx byte", rd, {24'h0, b});
		apb(1'b0, IDX_STATUS, 8'h00);
		check("rx flag", rd[ST_RX_FULL], 32'd0);
		for (int s = 0; s < 4; s++)
		begin
			bt = bit_time(pf[s], s & 1, s);
			peer.tx_bt = bt;
			apb(1'b1, IDX_TX_EXT, 8'(s));
			apb(1'b1, IDX_BAUD, {2'(s), 3'(s & 1), 3'b000});
			apb(1'b1, IDX_DATA, 8'h00);
			for (n = 0; n < 20000 && txd !== 1'b0; n++)
				@(negedge clk);
			bound("tx start", n, 20000);
			for (n = 0; n < 20000 && txd === 1'b0; n++)
				@(negedge clk);
			bound("tx low", n, 20000);
			// start bit may lose up to one tick of its length
			ok = n <= 9 * bt + 1 && n >= 9 * bt - bt / 16 - 1;
			check("tx rate", ok, 32'd1);
			repeat (bt * 2) @(posedge clk);
		end
		bt = bit_time(PRE_F1, 2, 2);
		peer.rx_bt = bt;
		apb(1'b1, IDX_RX_EXT, 8'h02);
		apb(1'b1, IDX_BAUD, 8'h42);
		seed = lfsr(seed);
		peer.send(seed);
		apb(1'b0, IDX_DATA, 8'h00);
		check("rx rate", rd, {24'h0, seed});
		// reset in mid-run drops the extended prescalers again
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b0, IDX_RX_EXT, 8'h00);
		check("rx ext after reset", rd, 32'h0);
		apb(1'b0, IDX_TX_EXT, 8'h00);
		check("tx ext after reset", rd, 32'h0);
		complete_run();
	end
endmodule : serial_rate_data_unit_tb
